// file: scr_pkg.sv
// Constants for the set/clear/toggle register bank
// How it works
// - A read/write bit reads back what was stored and takes each value software writes.
// - A read-only bit reads its live value and ignores every write.
// - A write-only bit accepts writes and its read value is not to be relied on.
// - Reserved bits always read as zero whatever was written.
// - Every register takes its reset value at power-on and again on a peripheral soft reset, debug control excepted.
// - A set, clear or toggle alias changes its base register in one write without read-modify-write.
// - A one written to the clear alias clears that base bit, and the alias reads the result.
// - A one written to the set alias sets that base bit, and the alias reads the result.
// - A one written to the toggle alias inverts that base bit, and the alias reads the result.
// - Both registers of a base/alias pair read the same base content.
package scr_pkg;
	// ----------------------------------------
	// Register index map
	// ----------------------------------------
	localparam int          DATA_W      = 8;
	localparam int          ADDR_W      = 3;
	localparam logic [2:0]  IDX_BASE    = 3'h0;
	localparam logic [2:0]  IDX_SET     = 3'h1;
	localparam logic [2:0]  IDX_CLEAR   = 3'h2;
	localparam logic [2:0]  IDX_TOGGLE  = 3'h3;
	localparam logic [2:0]  IDX_CTRL    = 3'h4;
	localparam logic [2:0]  IDX_STATUS  = 3'h5;
	localparam logic [2:0]  IDX_KEY     = 3'h6;
	localparam logic [2:0]  IDX_DEBUG   = 3'h7;
	// ----------------------------------------
	// Field masks and reset values
	// ----------------------------------------
	localparam logic [7:0]  CTRL_MASK   = 8'h0F;
	localparam logic [7:0]  BASE_RESET  = 8'h00;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [7:0]  DEBUG_RESET = 8'h00;
	localparam logic [7:0]  DEBUG_MASK  = 8'h03;
	localparam logic [7:0]  ZERO_BYTE   = 8'h00;
	// Alias operations
	typedef enum logic [1:0] {SCR_OP_NONE, SCR_OP_SET, SCR_OP_CLEAR, SCR_OP_TOGGLE} scr_op_e;
endpackage

// file: scr_alias_if.sv
// Interface between bank and its alias update unit
`timescale 1ns/10ps
`default_nettype none
interface scr_alias_if;
	logic [7:0]      base;
	logic [7:0]      wdata;
	scr_pkg::scr_op_e op;
	logic [7:0]      result;
	modport bank  (output base, output wdata, output op, input result);
	modport unit  (input base, input wdata, input op, output result);
endinterface
`default_nettype wire

// file: scr_alias_unit.sv
// Combinational set/clear/toggle update of one base register
`timescale 1ns/10ps
`default_nettype none
module scr_alias_unit (
	// Bank side
	scr_alias_if.unit port
);
	// Apply alias operation, zero bits keep their value
	always_comb begin
		unique case (port.op)
			scr_pkg::SCR_OP_SET:    port.result = port.base | port.wdata;
			scr_pkg::SCR_OP_CLEAR:  port.result = port.base & ~port.wdata;
			scr_pkg::SCR_OP_TOGGLE: port.result = port.base ^ port.wdata;
			scr_pkg::SCR_OP_NONE:   port.result = port.base;
		endcase
	end
endmodule
`default_nettype wire

// file: scr_bank.sv
// Register bank with base, set, clear and toggle aliases
`timescale 1ns/10ps
`default_nettype none
module scr_bank (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        softReset,
	// Register access
	input  wire logic        wrEn,
	input  wire logic        rdEn,
	input  wire logic [2:0]  addr,
	input  wire logic [7:0]  wdata,
	output var  logic [7:0]  rdata,
	// Peripheral side
	input  wire logic [7:0]  hwStatus,
	output var  logic [7:0]  baseOut,
	output var  logic [3:0]  ctrlOut,
	output var  logic [7:0]  keyOut,
	output var  logic [1:0]  debugOut
);
	logic [7:0] baseReg;
	logic [7:0] ctrlReg;
	logic [7:0] keyReg;
	logic [7:0] debugReg;
	logic [7:0] next_baseReg;
	logic [7:0] next_ctrlReg;
	logic [7:0] next_keyReg;
	logic [7:0] next_debugReg;
	logic [7:0] next_rdata;

	scr_alias_if aliasBus ();

	// ----------------------------------------
	// Alias update
	// ----------------------------------------
	scr_alias_unit aliasUnit (
		.port (aliasBus.unit)
	);

	// Drive alias unit from the decoded write
	always_comb begin
		aliasBus.base  = baseReg;
		aliasBus.wdata = wdata;
		aliasBus.op    = scr_pkg::SCR_OP_NONE;
		if (wrEn) begin
			unique case (addr)
				scr_pkg::IDX_SET:    aliasBus.op = scr_pkg::SCR_OP_SET;
				scr_pkg::IDX_CLEAR:  aliasBus.op = scr_pkg::SCR_OP_CLEAR;
				scr_pkg::IDX_TOGGLE: aliasBus.op = scr_pkg::SCR_OP_TOGGLE;
				default:             aliasBus.op = scr_pkg::SCR_OP_NONE;
			endcase
		end
	end

	// ----------------------------------------
	// Next register state
	// ----------------------------------------
	always_comb begin
		next_baseReg  = aliasBus.result;
		next_ctrlReg  = ctrlReg;
		next_keyReg   = keyReg;
		next_debugReg = debugReg;
		if (wrEn) begin
			unique case (addr)
				scr_pkg::IDX_BASE:  next_baseReg  = wdata;
				scr_pkg::IDX_CTRL:  next_ctrlReg  = wdata & scr_pkg::CTRL_MASK;
				scr_pkg::IDX_KEY:   next_keyReg   = wdata;
				scr_pkg::IDX_DEBUG: next_debugReg = wdata & scr_pkg::DEBUG_MASK;
				default: ;
			endcase
		end
		if (softReset) begin
			next_baseReg = scr_pkg::BASE_RESET;
			next_ctrlReg = scr_pkg::CTRL_RESET;
			next_keyReg  = scr_pkg::ZERO_BYTE;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		next_rdata = rdata;
		if (rdEn) begin
			unique case (addr)
				scr_pkg::IDX_BASE,
				scr_pkg::IDX_SET,
				scr_pkg::IDX_CLEAR,
				scr_pkg::IDX_TOGGLE: next_rdata = baseReg;
				scr_pkg::IDX_CTRL:   next_rdata = ctrlReg;
				scr_pkg::IDX_STATUS: next_rdata = hwStatus;
				scr_pkg::IDX_KEY:    next_rdata = scr_pkg::ZERO_BYTE;
				scr_pkg::IDX_DEBUG:  next_rdata = debugReg;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			baseReg  <= scr_pkg::BASE_RESET;
			ctrlReg  <= scr_pkg::CTRL_RESET;
			keyReg   <= scr_pkg::ZERO_BYTE;
			debugReg <= scr_pkg::DEBUG_RESET;
			rdata    <= scr_pkg::ZERO_BYTE;
			baseOut  <= scr_pkg::BASE_RESET;
			ctrlOut  <= 4'h0;
			keyOut   <= scr_pkg::ZERO_BYTE;
			debugOut <= 2'h0;
		end else begin
			baseReg  <= next_baseReg;
			ctrlReg  <= next_ctrlReg;
			keyReg   <= next_keyReg;
			debugReg <= next_debugReg;
			rdata    <= next_rdata;
			baseOut  <= next_baseReg;
			ctrlOut  <= next_ctrlReg[3:0];
			keyOut   <= next_keyReg;
			debugOut <= next_debugReg[1:0];
		end
	end
endmodule
`default_nettype wire

// file: scr_bank_asserts.sv
// Port checks for the register bank
`timescale 1ns/10ps
`default_nettype none
module scr_bank_asserts (
	// Watched ports
	input wire logic       core_clk, resetn, softReset, wrEn, rdEn,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata, rdata, hwStatus, baseOut, keyOut,
	input wire logic [1:0] debugOut
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn || softReset);
	a_base_wr: assert property (wrEn&&addr==3'h0|=>baseOut==$past(wdata)) else $error("base");
	a_set_op: assert property (wrEn&&addr==3'h1|=>baseOut==($past(baseOut)|$past(wdata))) else $error("set");
	a_zero_op: assert property (wrEn&&addr==3'h2|=>baseOut==($past(baseOut)&~$past(wdata))) else $error("zero");
	a_flip_op: assert property (wrEn&&addr==3'h3|=>baseOut==($past(baseOut)^$past(wdata))) else $error("flip");
	a_ro_status: assert property (rdEn&&addr==3'h5|=>rdata==$past(hwStatus)) else $error("status");
	a_pair_read: assert property (rdEn&&addr<3'h4|=>rdata==$past(baseOut)) else $error("pair");
	a_rsvd_zero: assert property (rdEn&&addr==3'h7|=>rdata[7:2]==6'h00) else $error("reserved");
	a_soft_rst: assert property (disable iff (!resetn) softReset&&!(wrEn&&addr==3'h7)|=>baseOut==8'h00&&keyOut==8'h00
		&&debugOut==$past(debugOut)) else $error("soft");
endmodule
`default_nettype wire

// file: scr_bank_tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
module scr_bank_tb_top;
	logic       core_clk = 1'h0, resetn = 1'h0, softReset = 1'h0, wrEn = 1'h0, rdEn = 1'h0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, hwStatus = 8'h00, rdata, baseOut, keyOut;
	logic [1:0] debugOut;
	logic [3:0] ctrlOut;
	int         n_fail = 0, checks_done = 0;
	scr_bank scr_bank_inst (.core_clk, .resetn, .softReset, .wrEn, .rdEn, .addr, .wdata, .rdata,
		.hwStatus, .baseOut, .ctrlOut, .keyOut, .debugOut);
	initial forever #5 core_clk = ~core_clk;
	task chk(input logic [7:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h", $time, got);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk) #1 {wrEn, addr, wdata} = {1'h1, a, d};
		@(posedge core_clk) #1 wrEn = 1'h0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge core_clk) #1 {rdEn, addr} = {1'h1, a};
		@(posedge core_clk) #1 rdEn = 1'h0;
		chk(rdata, e);
	endtask
	task t_alias();
		wr(3'h0, 8'hC3);
		wr(3'h1, 8'h0C);
		rd(3'h1, 8'hCF);
		wr(3'h2, 8'h81);
		rd(3'h2, 8'h4E);
		wr(3'h3, 8'hF0);
		rd(3'h3, 8'hBE);
		rd(3'h0, 8'hBE);
	endtask
	task t_regs();
		hwStatus = 8'h3C;
		wr(3'h5, 8'hFF);
		rd(3'h5, 8'h3C);
		wr(3'h6, 8'h5A);
		chk(keyOut, 8'h5A);
		wr(3'h7, 8'hFF);
		rd(3'h7, 8'h03);
		wr(3'h4, 8'h0A);
		rd(3'h4, 8'h0A);
		chk({4'h0, ctrlOut}, 8'h0A);
		wr(3'h4, 8'hFF);
		rd(3'h4, 8'h0F);
		chk({4'h0, ctrlOut}, 8'h0F);
		wr(3'h1, 8'h00);
		rd(3'h0, 8'hBE);
	endtask
	task t_soft();
		@(posedge core_clk) #1 softReset = 1'h1;
		@(posedge core_clk) #1 softReset = 1'h0;
		chk(keyOut, 8'h00);
		chk({4'h0, ctrlOut}, 8'h00);
		rd(3'h0, 8'h00);
		rd(3'h7, 8'h03);
	endtask
	task tally_and_finish();
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		#1 resetn = 1'h1;
		chk(baseOut, 8'h00);
		t_alias();
		t_regs();
		t_soft();
		tally_and_finish();
	end
endmodule
bind scr_bank scr_bank_asserts scr_bank_asserts_inst (.core_clk, .resetn, .softReset, .wrEn, .rdEn, .addr,
	.wdata, .rdata, .hwStatus, .baseOut, .keyOut, .debugOut);
`default_nettype wire
